// ### src/egf_exposure_gain_frame_ctrl.sv
/*
 * Exposure, gain, white-balance, compensation and framing register bank
 * with frame-boundary gain latching.
 * Assumes the serial control bus front end gives byte accesses on the
 * same clock, and that frameStart and compComputed come from logic on
 * the same clock.
 */
`timescale 1ns/1ps

module egf_exposure_gain_frame_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register access from the serial control front end
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Frame timing and internal status
    input wire logic frameStart,
    input wire logic [9:0] compComputed,
    // Settings to the sensor core
    output egf_pkg::egf_frame_cfg_t frameCfg,
    output egf_pkg::egf_gain_cfg_t gainCfg,
    output egf_pkg::egf_comp_cfg_t compCfg,
    output logic [9:0] appliedGain,
    output logic [11:0] gainX16,
    output logic blcKick
);

    // ------------------------------------------------------------------
    // Register storage and address decode
    // ------------------------------------------------------------------
    logic [7:0] regs_q [egf_pkg::NUM_RW];
    logic [egf_pkg::NUM_RW-1:0] hit;
    logic [7:0] selByte [egf_pkg::NUM_RW];

    // One decoder and one byte register per read/write bank address
    for (genvar i = 0; i < egf_pkg::NUM_RW; i++)
    begin : g_reg
        assign hit[i] = (regAddr == egf_pkg::REG_OFFSET[i]);
        assign selByte[i] = hit[i] ? regs_q[i] : 8'h00;
        always_ff @(posedge clock)
        begin
            if (!rst_n)
                regs_q[i] <= egf_pkg::REG_RESET[i];
            else if (regWrEn && hit[i])
                regs_q[i] <= regWrData;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] rwByte;
    logic compHiHit;
    logic compLoHit;
    logic anyHit;
    logic [7:0] rdByte;
    logic [7:0] regRdData_q;
    logic regRdValid_q;

    // OR of the one-hot selected bytes
    always_comb
    begin
        rwByte = 8'h00;
        for (int k = 0; k < egf_pkg::NUM_RW; k++)
            rwByte = rwByte | selByte[k];
    end

    // Computed value is live, not a snapshot; unmapped addresses read zero
    assign compHiHit = (regAddr == egf_pkg::OFF_COMP_COMPUTED_HI);
    assign compLoHit = (regAddr == egf_pkg::OFF_COMP_COMPUTED_LO);
    assign anyHit = (|hit) | compHiHit | compLoHit;
    assign rdByte = compHiHit ? {6'h00, compComputed[9:8]} :
                    compLoHit ? compComputed[7:0] : rwByte;

    // Read data answers one cycle after the request and holds until the next
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            regRdData_q <= 8'h00;
            regRdValid_q <= 1'b0;
        end
        else
        begin
            regRdValid_q <= regRdEn;
            if (regRdEn)
                regRdData_q <= rdByte;
        end
    end

    assign regRdData = regRdData_q;
    assign regRdValid = regRdValid_q;

    // ------------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------------
    logic [7:0] gainCtrl;
    logic [7:0] convCtrl;
    logic [7:0] compCtrl;
    logic [15:0] exposureVal;
    logic noDelay;
    logic convLinear;
    logic snrManEn;
    logic [9:0] srcGain;
    logic [9:0] compManVal;
    logic [9:0] compVal;
    egf_pkg::egf_frame_cfg_t frameCfg_d;
    egf_pkg::egf_gain_cfg_t gainCfg_d;
    egf_pkg::egf_comp_cfg_t compCfg_d;

    assign gainCtrl = regs_q[egf_pkg::IDX_EXPO_GAIN_CTRL];
    assign convCtrl = regs_q[egf_pkg::IDX_GAIN_CONVERT];
    assign compCtrl = regs_q[egf_pkg::IDX_COMP_CTRL];
    assign exposureVal = {regs_q[egf_pkg::IDX_EXPO_TOP][3:0],
                          regs_q[egf_pkg::IDX_EXPO_MID],
                          regs_q[egf_pkg::IDX_EXPO_LOW][7:4]};
    assign noDelay = convCtrl[egf_pkg::BIT_GAIN_NO_DELAY];
    assign convLinear = convCtrl[egf_pkg::BIT_GAIN_CONVERT];
    assign snrManEn = convCtrl[egf_pkg::BIT_SNR_MAN_EN];

    // Gain source: manual sensor gain pair or the gain output pair
    assign srcGain = snrManEn ? {regs_q[egf_pkg::IDX_MAN_GAIN_HI][1:0],
                                 regs_q[egf_pkg::IDX_MAN_GAIN_LO]}
                              : {regs_q[egf_pkg::IDX_GAIN_OUT_HI][1:0],
                                 regs_q[egf_pkg::IDX_GAIN_OUT_LO]};

    // Compensation value: manual only while manual compensation is enabled
    assign compManVal = compCtrl[egf_pkg::BIT_COMP_MAN_OPT] ?
                        {regs_q[egf_pkg::IDX_COMP_MAN_HI][1:0],
                         regs_q[egf_pkg::IDX_COMP_MAN_LO]} : egf_pkg::COMP_FIXED;
    assign compVal = compCtrl[egf_pkg::BIT_COMP_MAN_EN] ? compManVal : compComputed;

    // Window, size and timing pairs, high byte first
    assign frameCfg_d.xStart = {regs_q[16], regs_q[17]};
    assign frameCfg_d.yStart = {regs_q[18], regs_q[19]};
    assign frameCfg_d.xEnd = {regs_q[20], regs_q[21]};
    assign frameCfg_d.yEnd = {regs_q[22], regs_q[23]};
    assign frameCfg_d.outWidth = {regs_q[24], regs_q[25]};
    assign frameCfg_d.outHeight = {regs_q[26], regs_q[27]};
    assign frameCfg_d.lineLength = {regs_q[28], regs_q[29]};
    assign frameCfg_d.frameLength = {regs_q[30], regs_q[31]};
    assign frameCfg_d.xOffset = {regs_q[32], regs_q[33]};
    assign frameCfg_d.yOffset = {regs_q[34], regs_q[35]};
    assign frameCfg_d.xOddInc = regs_q[egf_pkg::IDX_H_STEP][7:4];
    assign frameCfg_d.xEvenInc = regs_q[egf_pkg::IDX_H_STEP][3:0];
    assign frameCfg_d.yOddInc = regs_q[egf_pkg::IDX_V_STEP][7:4];
    assign frameCfg_d.yEvenInc = regs_q[egf_pkg::IDX_V_STEP][3:0];
    assign frameCfg_d.vFlip = regs_q[egf_pkg::IDX_V_FORMAT][egf_pkg::BIT_VFLIP];
    assign frameCfg_d.vBin = regs_q[egf_pkg::IDX_V_FORMAT][egf_pkg::BIT_VBIN];
    assign frameCfg_d.hMirror = regs_q[egf_pkg::IDX_H_FORMAT][egf_pkg::BIT_HMIRROR];
    assign frameCfg_d.hBin = regs_q[egf_pkg::IDX_H_FORMAT][egf_pkg::BIT_HBIN];
    assign frameCfg_d.dBinEn = regs_q[egf_pkg::IDX_DBIN_CTRL][egf_pkg::BIT_DBIN_EN];
    assign frameCfg_d.dBinSum = regs_q[egf_pkg::IDX_DBIN_CTRL][egf_pkg::BIT_DBIN_SUM];
    assign frameCfg_d.dBinCtrl = regs_q[egf_pkg::IDX_DBIN_CTRL][3:2];

    // Exposure, balance and gain format settings
    assign gainCfg_d.exposure = exposureVal;
    assign gainCfg_d.wbRed = {regs_q[0][3:0], regs_q[1]};
    assign gainCfg_d.wbGreen = {regs_q[2][3:0], regs_q[3]};
    assign gainCfg_d.wbBlue = {regs_q[4][3:0], regs_q[5]};
    assign gainCfg_d.wbManual = regs_q[egf_pkg::IDX_WB_MANUAL][0];
    assign gainCfg_d.gainLinear = convLinear;
    assign gainCfg_d.snrManualEn = snrManEn;
    assign gainCfg_d.analogBits = regs_q[egf_pkg::IDX_ANALOG_BITS][3:0];
    assign gainCfg_d.digitalBits = regs_q[egf_pkg::IDX_DIGITAL_BITS][3:0];

    // Compensation enables, each active high
    assign compCfg_d.ditherEn = compCtrl[egf_pkg::BIT_DITHER_EN];
    assign compCfg_d.blcOnEn = compCtrl[egf_pkg::BIT_COMP_BLC_ON];
    assign compCfg_d.bypass = compCtrl[egf_pkg::BIT_COMP_BYPASS];
    assign compCfg_d.manualEn = compCtrl[egf_pkg::BIT_COMP_MAN_EN];
    assign compCfg_d.value = compVal;

    // ------------------------------------------------------------------
    // Frame-boundary gain latching
    // ------------------------------------------------------------------
    logic expWrite;
    logic expChanged_d;
    logic expChanged_q;
    logic useNext;
    logic [9:0] stage_q;
    logic [9:0] appliedGain_q;
    logic gainOutWrite;

    assign expWrite = regWrEn && (hit[egf_pkg::IDX_EXPO_TOP] || hit[egf_pkg::IDX_EXPO_MID]
                                  || hit[egf_pkg::IDX_EXPO_LOW]);
    // A write landing on the frame start still counts for the next frame
    assign expChanged_d = expWrite | (expChanged_q & ~frameStart);
    // Exposure-unchanged governs when chosen; otherwise the delay option bit
    assign useNext = gainCtrl[egf_pkg::BIT_DELAY_CHOICE] ?
                     ~(expChanged_q | expWrite) : gainCtrl[egf_pkg::BIT_GAIN_DELAY_OPT];
    assign gainOutWrite = regWrEn && (hit[egf_pkg::IDX_GAIN_OUT_HI]
                                      || hit[egf_pkg::IDX_GAIN_OUT_LO]);

    // Two-stage pipe: stage holds the value captured at the previous start
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            expChanged_q <= 1'b0;
            stage_q <= egf_pkg::GAIN_RESET;
            appliedGain_q <= egf_pkg::GAIN_RESET;
        end
        else
        begin
            expChanged_q <= expChanged_d;
            if (frameStart)
                stage_q <= srcGain;
            if (noDelay)
                appliedGain_q <= srcGain;
            else if (frameStart)
                appliedGain_q <= useNext ? srcGain : stage_q;
        end
    end

    // ------------------------------------------------------------------
    // Gain factor in sixteenths
    // ------------------------------------------------------------------
    logic [2:0] doubleCount;
    logic [11:0] sensorBase;
    logic [11:0] gainX16_d;

    // Each set bit of 7..4 doubles the gain
    assign doubleCount = 3'(appliedGain_q[7]) + 3'(appliedGain_q[6])
                       + 3'(appliedGain_q[5]) + 3'(appliedGain_q[4]);
    assign sensorBase = {7'h00, 1'b1, appliedGain_q[3:0]};
    assign gainX16_d = convLinear ? {2'b00, appliedGain_q}
                                  : (sensorBase << doubleCount);

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    egf_pkg::egf_frame_cfg_t frameCfg_q;
    egf_pkg::egf_gain_cfg_t gainCfg_q;
    egf_pkg::egf_comp_cfg_t compCfg_q;
    logic [11:0] gainX16_q;
    logic blcKick_q;

    // Settings follow the bank one cycle later so every output is a flop
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            frameCfg_q <= '0;
            gainCfg_q <= '0;
            compCfg_q <= '0;
            gainX16_q <= egf_pkg::GAIN_X16_RESET;
            blcKick_q <= 1'b0;
        end
        else
        begin
            frameCfg_q <= frameCfg_d;
            gainCfg_q <= gainCfg_d;
            compCfg_q <= compCfg_d;
            gainX16_q <= gainX16_d;
            blcKick_q <= gainOutWrite && !snrManEn;
        end
    end

    assign frameCfg = frameCfg_q;
    assign gainCfg = gainCfg_q;
    assign compCfg = compCfg_q;
    assign appliedGain = appliedGain_q;
    assign gainX16 = gainX16_q;
    assign blcKick = blcKick_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence expoMidWrite;
        regWrEn && hit[egf_pkg::IDX_EXPO_MID] ##1 !expWrite;
    endsequence

    chk_expo_mid_byte: assert property (
        expoMidWrite |=> gainCfg.exposure[11:4] == $past(regWrData, 2))
        else $error("exposure middle byte not placed in bits 11:4");

    chk_gain_next_frame: assert property (
        frameStart && !noDelay && !gainCtrl[4] && gainCtrl[5]
        |=> appliedGain == $past(srcGain))
        else $error("gain not latched at next frame start");

    chk_gain_late_frame: assert property (
        frameStart && !noDelay && !gainCtrl[4] && !gainCtrl[5]
        |=> appliedGain == $past(stage_q))
        else $error("gain not delayed by one frame");

    chk_gain_exp_changed: assert property (
        frameStart && !noDelay && gainCtrl[4] && expChanged_q
        |=> appliedGain == $past(stage_q))
        else $error("gain latched despite exposure change");

    chk_gain_exp_same: assert property (
        frameStart && !noDelay && gainCtrl[4] && !expChanged_q && !expWrite
        |=> appliedGain == $past(srcGain))
        else $error("gain held although exposure unchanged");

    chk_gain_no_delay: assert property (
        noDelay |=> appliedGain == $past(srcGain))
        else $error("gain not applied at once");

    chk_gain_hold: assert property (
        !noDelay && !frameStart |=> $stable(appliedGain))
        else $error("gain moved between frame starts");

    chk_linear_factor: assert property (
        convLinear |=> gainX16 == {2'b00, $past(appliedGain)})
        else $error("linear gain factor wrong");

    chk_sensor_factor: assert property (
        !convLinear && appliedGain[7:0] == 8'hF0 |=> gainX16 == 12'h100)
        else $error("sensor gain product wrong");

    chk_comp_fixed: assert property (
        compCtrl[0] && !compCtrl[1] |=> compCfg.value == 10'h200)
        else $error("fixed compensation not 512");

    chk_comp_readback: assert property (
        regRdEn && compLoHit |=> regRdValid && regRdData == $past(compComputed[7:0]))
        else $error("computed compensation low byte misread");

    chk_manual_no_kick: assert property (
        snrManEn |=> !blcKick)
        else $error("recalibration kicked under manual sensor gain");

    chk_unmapped_zero: assert property (
        regRdEn && !anyHit |=> regRdData == 8'h00)
        else $error("unmapped address read non-zero");

endmodule // egf_exposure_gain_frame_ctrl

// ### src/egf_pkg.sv
/*
 * Constants, register map and carrier types for the exposure, gain and
 * frame control register bank.
 * Assumes byte-wide registers on a 16-bit register address space.
 */
package egf_pkg;

    // ------------------------------------------------------------------
    // Register map (read/write bank, table order)
    // ------------------------------------------------------------------
    localparam int NUM_RW = 46;

    localparam logic [15:0] REG_OFFSET [NUM_RW] = '{
        16'h3400, 16'h3401, 16'h3402, 16'h3403, 16'h3404, 16'h3405, 16'h3406,
        16'h3500, 16'h3501, 16'h3502, 16'h3503, 16'h3504, 16'h3505, 16'h3509,
        16'h350A, 16'h350B, 16'h3800, 16'h3801, 16'h3802, 16'h3803, 16'h3804,
        16'h3805, 16'h3806, 16'h3807, 16'h3808, 16'h3809, 16'h380A, 16'h380B,
        16'h380C, 16'h380D, 16'h380E, 16'h380F, 16'h3810, 16'h3811, 16'h3812,
        16'h3813, 16'h3814, 16'h3815, 16'h3820, 16'h3821, 16'h3837, 16'h5D00,
        16'h5D01, 16'h5F00, 16'h5F02, 16'h5F03};

    localparam logic [7:0] REG_RESET [NUM_RW] = '{
        8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h01,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
        8'h00, 8'h10, 8'h00, 8'h04, 8'h00, 8'h04, 8'h02,
        8'h8B, 8'h01, 8'hEB, 8'h02, 8'h80, 8'h01, 8'hE0,
        8'h03, 8'h04, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h11, 8'h11, 8'h00, 8'h00, 8'h00, 8'h07,
        8'h00, 8'h18, 8'h02, 8'h00};

    // Read-only computed compensation value
    localparam logic [15:0] OFF_COMP_COMPUTED_HI = 16'h5F04;
    localparam logic [15:0] OFF_COMP_COMPUTED_LO = 16'h5F05;

    // Indices into the read/write bank
    localparam int IDX_WB_RED_HI = 0;
    localparam int IDX_WB_MANUAL = 6;
    localparam int IDX_EXPO_TOP = 7;
    localparam int IDX_EXPO_MID = 8;
    localparam int IDX_EXPO_LOW = 9;
    localparam int IDX_EXPO_GAIN_CTRL = 10;
    localparam int IDX_MAN_GAIN_HI = 11;
    localparam int IDX_MAN_GAIN_LO = 12;
    localparam int IDX_GAIN_CONVERT = 13;
    localparam int IDX_GAIN_OUT_HI = 14;
    localparam int IDX_GAIN_OUT_LO = 15;
    localparam int IDX_WINDOW_X_START_HI = 16;
    localparam int IDX_H_STEP = 36;
    localparam int IDX_V_STEP = 37;
    localparam int IDX_V_FORMAT = 38;
    localparam int IDX_H_FORMAT = 39;
    localparam int IDX_DBIN_CTRL = 40;
    localparam int IDX_ANALOG_BITS = 41;
    localparam int IDX_DIGITAL_BITS = 42;
    localparam int IDX_COMP_CTRL = 43;
    localparam int IDX_COMP_MAN_HI = 44;
    localparam int IDX_COMP_MAN_LO = 45;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_GAIN_DELAY_OPT = 5;
    localparam int BIT_DELAY_CHOICE = 4;
    localparam int BIT_GAIN_CONVERT = 4;
    localparam int BIT_SNR_MAN_EN = 3;
    localparam int BIT_GAIN_NO_DELAY = 1;
    localparam int BIT_DITHER_EN = 4;
    localparam int BIT_COMP_BLC_ON = 3;
    localparam int BIT_COMP_BYPASS = 2;
    localparam int BIT_COMP_MAN_OPT = 1;
    localparam int BIT_COMP_MAN_EN = 0;
    localparam int BIT_VFLIP = 2;
    localparam int BIT_VBIN = 1;
    localparam int BIT_HMIRROR = 2;
    localparam int BIT_HBIN = 0;
    localparam int BIT_DBIN_EN = 0;
    localparam int BIT_DBIN_SUM = 1;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [9:0] COMP_FIXED = 10'h200;
    localparam logic [9:0] GAIN_RESET = 10'h010;
    localparam logic [11:0] GAIN_X16_RESET = 12'h010;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] xStart;
        logic [15:0] yStart;
        logic [15:0] xEnd;
        logic [15:0] yEnd;
        logic [15:0] outWidth;
        logic [15:0] outHeight;
        logic [15:0] lineLength;
        logic [15:0] frameLength;
        logic [15:0] xOffset;
        logic [15:0] yOffset;
        logic [3:0] xOddInc;
        logic [3:0] xEvenInc;
        logic [3:0] yOddInc;
        logic [3:0] yEvenInc;
        logic vFlip;
        logic vBin;
        logic hMirror;
        logic hBin;
        logic dBinEn;
        logic dBinSum;
        logic [1:0] dBinCtrl;
    } egf_frame_cfg_t;

    typedef struct packed {
        logic [15:0] exposure;
        logic [11:0] wbRed;
        logic [11:0] wbGreen;
        logic [11:0] wbBlue;
        logic wbManual;
        logic gainLinear;
        logic snrManualEn;
        logic [3:0] analogBits;
        logic [3:0] digitalBits;
    } egf_gain_cfg_t;

    typedef struct packed {
        logic ditherEn;
        logic blcOnEn;
        logic bypass;
        logic manualEn;
        logic [9:0] value;
    } egf_comp_cfg_t;

endpackage

// ### test/test_exposure_gain_frame_control_regs.sv
/*
 * Self-checking bench for the exposure, gain and frame control bank.
 * Assumes the same-clock byte port and in-design assertions.
 */
`timescale 1ns/1ps

module test_exposure_gain_frame_control_regs;
    // -----------------------------------------------------------
    // Signals
    // -----------------------------------------------------------
    logic clock, rst_n, regWrEn, regRdEn, frameStart, regRdValid, blcKick;
    logic [15:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic [9:0] compComputed, appliedGain;
    logic [11:0] gainX16;
    egf_pkg::egf_frame_cfg_t frameCfg;
    egf_pkg::egf_gain_cfg_t gainCfg;
    egf_pkg::egf_comp_cfg_t compCfg;
    int nFail, compares, kicks, k;

    egf_exposure_gain_frame_ctrl u_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .frameStart(frameStart), .compComputed(compComputed),
        .frameCfg(frameCfg), .gainCfg(gainCfg), .compCfg(compCfg),
        .appliedGain(appliedGain), .gainX16(gainX16), .blcKick(blcKick));

    // Clock, and a count of recalibration kicks
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (blcKick === 1'b1) kicks <= kicks + 1;

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            nFail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes rise and fall a full cycle apart, so calls never collide
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clock);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clock);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clock);
        regRdEn = 1'b0;
        chk(16'(regRdValid), 16'h0001);
        chk(16'(regRdData), 16'(e));
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One-cycle frame start, then room for the gain code to follow
    task automatic frame(input logic [9:0] e);
        @(negedge clock);
        frameStart = 1'b1;
        @(negedge clock);
        frameStart = 1'b0;
        settle(1);
        chk(16'(appliedGain), 16'(e));
    endtask
    task automatic completeRun();
        $display("checks %0d, mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial
    begin
        {rst_n, regWrEn, regRdEn, frameStart, regAddr, regWrData} = '0;
        compComputed = 10'h2A5;
        {nFail, compares} = '0;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        // Reset state: unity gain, no read answer pending
        chk(16'(appliedGain), 16'h0010);
        chk(16'(gainX16), 16'h0010);
        chk(16'(regRdValid), 16'h0000);
        // Reset values, then a distinct byte through every register
        for (int i = 0; i < egf_pkg::NUM_RW; i++) rd(egf_pkg::REG_OFFSET[i], egf_pkg::REG_RESET[i]);
        rd(16'h1234, 8'h00);
        for (int i = 0; i < egf_pkg::NUM_RW; i++) wr(egf_pkg::REG_OFFSET[i], 8'hA5 ^ 8'(i));
        for (int i = 0; i < egf_pkg::NUM_RW; i++) rd(egf_pkg::REG_OFFSET[i], 8'hA5 ^ 8'(i));
        wr(16'h5F04, 8'hFF);
        rd(16'h5F04, 8'h02);
        rd(16'h5F05, 8'hA5);
        chk(16'(gainCfg.wbRed), 16'h05A4);
        chk(16'(gainCfg.wbManual), 16'h0001);
        chk(frameCfg.xStart, 16'hB5B4);
        chk(frameCfg.outWidth, 16'hBDBC);
        chk(frameCfg.frameLength, 16'hBBBA);
        chk(frameCfg.yEnd, 16'hB3B2);
        chk(frameCfg.lineLength, 16'hB9B8);
        chk(frameCfg.yOffset, 16'h8786);
        chk(16'(gainCfg.wbBlue), 16'h01A0);
        chk(16'({gainCfg.gainLinear, gainCfg.snrManualEn}), 16'h0001);
        chk(16'({gainCfg.analogBits, gainCfg.digitalBits}), 16'h00CF);
        // Exposure packed from its three bytes, then step and format fields
        wr(16'h3500, 8'hF5);
        wr(16'h3501, 8'h3C);
        wr(16'h3502, 8'h7F);
        wr(16'h3814, 8'h35);
        wr(16'h3820, 8'h06);
        wr(16'h3821, 8'h05);
        wr(16'h3837, 8'h0F);
        settle(2);
        chk(gainCfg.exposure, 16'h53C7);
        chk(16'({frameCfg.xOddInc, frameCfg.xEvenInc}), 16'h0035);
        chk(16'({frameCfg.yOddInc, frameCfg.yEvenInc}), 16'h0080);
        chk(16'({frameCfg.vFlip, frameCfg.vBin, frameCfg.hMirror, frameCfg.hBin}), 16'h000F);
        chk(16'({frameCfg.dBinCtrl, frameCfg.dBinSum, frameCfg.dBinEn}), 16'h000F);
        // Compensation: fixed, programmed, then computed value
        wr(16'h5F00, 8'h1D);
        settle(2);
        chk(16'({compCfg.ditherEn, compCfg.blcOnEn, compCfg.bypass}), 16'h0007);
        chk(16'(compCfg.value), 16'h0200);
        wr(16'h5F00, 8'h03);
        wr(16'h5F02, 8'h01);
        wr(16'h5F03, 8'h34);
        settle(2);
        chk(16'(compCfg.value), 16'h0134);
        chk(16'(compCfg.manualEn), 16'h0001);
        wr(16'h5F00, 8'h00);
        settle(2);
        chk(16'(compCfg.value), 16'h02A5);
        // Immediate gain: manual sensor gain never kicks recalibration
        wr(16'h3509, 8'h0A);
        k = kicks;
        wr(16'h3504, 8'h03);
        wr(16'h3505, 8'h21);
        settle(3);
        chk(16'(appliedGain), 16'h0321);
        chk(16'(kicks - k), 16'h0000);
        wr(16'h3509, 8'h12);
        wr(16'h350A, 8'h01);
        wr(16'h350B, 8'h40);
        settle(3);
        chk(16'(gainX16), 16'h0140);
        chk(16'(kicks - k), 16'h0002);
        wr(16'h3509, 8'h02);
        wr(16'h350A, 8'h00);
        // All four doubling bits set, zero fraction: sixteen times unity
        wr(16'h350B, 8'hF0);
        settle(3);
        chk(16'(gainX16), 16'h0100);
        wr(16'h350B, 8'h53);
        settle(3);
        chk(16'(gainX16), 16'h004C);
        // Frame-latched gain, option bit and exposure-unchanged choice
        wr(16'h3509, 8'h10);
        wr(16'h3503, 8'h22);
        wr(16'h350B, 8'h20);
        settle(2);
        chk(16'(appliedGain), 16'h0053);
        frame(10'h020);
        chk(16'(gainX16), 16'h0020);
        wr(16'h3503, 8'h02);
        wr(16'h350B, 8'h30);
        frame(10'h020);
        frame(10'h030);
        wr(16'h3503, 8'h12);
        wr(16'h3501, 8'h11);
        wr(16'h350B, 8'h44);
        frame(10'h030);
        frame(10'h044);
        wr(16'h350B, 8'h55);
        frame(10'h055);
        completeRun();
    end
endmodule // test_exposure_gain_frame_control_regs
